// File: rctc_top.sv
// Scan sequencer and pin logic for the multi-channel resonant touch block.
`timescale 1ns/1ps
module rctc_top
  import rctc_pkg::*;
#(
  parameter int unsigned P_NUM_CH      = NUM_CH,       // 4, or 2 for the two-channel build.
  parameter int unsigned P_UNIT_CYCLES = UNIT_CYCLES   // Cycles in one 0.5 us unit.
) (
  input  wire logic                          i_clock,                 // 200 MHz clock.
  input  wire logic                          i_arst_n,                // Asynchronous reset, active low.
  input  wire logic [NUM_CH-1:0]             i_chan_enable,           // Per-channel enable.
  input  wire logic [NUM_CH-1:0]             i_data_sign_select,      // Result polarity per channel.
  input  wire logic [NUM_CH-1:0][GAIN_W-1:0] i_sensitivity_step,      // Gain step per channel.
  input  wire logic [EXP_W-1:0]              i_normal_drift_exponent, // Normal baseline exponent.
  input  wire logic [EXP_W-1:0]              i_lowpower_drift_exponent, // Low power baseline exponent.
  input  wire logic                          i_low_power_mode,        // 1 selects low power scanning.
  input  wire logic [MTIME_W-1:0]            i_meas_time_sel,         // Measure time (sel+1)*0.5 us.
  input  wire logic [WAIT_W-1:0]             i_scan_wait,             // Sleep units between scans.
  input  wire logic [NUM_CH-1:0]             i_indicator_active_high, // Indicator active level.
  input  wire logic                          i_alert_active_high,     // Alert polarity register.
  input  wire logic [MEAS_W-1:0]             i_meas_value,            // Front-end frequency count.
  input  wire logic                          i_meas_error,            // Front-end error level.
  output logic                               o_meas_req,              // Measuring current channel.
  output logic [1:0]                         o_meas_chan,             // Channel being measured.
  output logic                               o_low_power_state,       // Sleeping between scans.
  output logic                               o_scan_done,             // One-cycle end of scan.
  output logic [NUM_CH-1:0]                  o_detect_indicator_pin,  // Push-pull indicators.
  output logic                               o_alert_pin_n,           // Alert pin.
  output logic [NUM_CH-1:0]                  o_detect_status,         // Detection flags.
  output logic [NUM_CH-1:0][RES_W-1:0]       o_channel_result         // Channel results.
);

  rctc_top_s q, d;

  logic [NUM_CH-1:0]        en_eff;
  logic [NUM_CH-1:0]        det;
  logic [NUM_CH-1:0][RES_W-1:0] res;
  logic [UNIT_W-1:0]        wait_units;
  logic [UNIT_W-1:0]        meas_units;
  logic                     unit_tick;
  logic                     last_ch;

  ////////////////////////////////////////////////////////////////////////////////
  // Effective enables: the two-channel build cannot switch its channels off.
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (i >= P_NUM_CH) begin
        en_eff[i] = 1'b0;
      end else if (P_NUM_CH == 2) begin
        en_eff[i] = 1'b1;
      end else begin
        en_eff[i] = i_chan_enable[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Time bases. Low power stretches the sleep so scans come less often; never zero.
  always_comb begin
    wait_units = (i_low_power_mode ? (UNIT_W'(i_scan_wait) << LP_WAIT_SHIFT)
                                   : UNIT_W'(i_scan_wait));
    if (wait_units == '0) begin
      wait_units = UNIT_W'(1);
    end
    meas_units = UNIT_W'(i_meas_time_sel) + UNIT_W'(1);
    unit_tick  = (q.tick == TICK_W'(P_UNIT_CYCLES - 1));
    last_ch    = (q.ch == 2'(P_NUM_CH - 1));
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer: measure, evaluate, report, sleep, repeat.
  always_comb begin
    d = q;
    d.sample_stb = 1'b0;
    d.eval_stb   = 1'b0;
    d.scan_done  = 1'b0;
    d.tick       = unit_tick ? '0 : q.tick + TICK_W'(1);
    if (unit_tick) begin
      d.units = q.units + UNIT_W'(1);
    end
    if (i_meas_error) begin
      d.err_seen = 1'b1;
    end
    case (q.st)
      ST_SLEEP: begin
        if (unit_tick && (q.units + UNIT_W'(1) >= wait_units)) begin
          d.st       = ST_MEAS;
          d.ch       = '0;
          d.tick     = '0;
          d.units    = '0;
          d.err_seen = i_meas_error;
        end
      end
      ST_MEAS: begin
        if (q.sample_stb) begin
          // The sample lands in its own channel this cycle, so the index moves on only now.
          d.tick     = '0;
          d.units    = '0;
          d.eval_stb = last_ch;
          d.ch       = last_ch ? q.ch : q.ch + 2'd1;
          d.st       = last_ch ? ST_EVAL : ST_MEAS;
        end else if (!en_eff[q.ch]) begin
          // A disabled channel costs one cycle and is not measured.
          d.meas_req = 1'b0;
          d.tick     = '0;
          d.units    = '0;
          d.eval_stb = last_ch;
          d.ch       = q.ch + 2'd1;
          d.st       = last_ch ? ST_EVAL : ST_MEAS;
        end else begin
          d.meas_req = 1'b1;
          if (unit_tick && (q.units + UNIT_W'(1) >= meas_units)) begin
            d.meas_req   = 1'b0;
            d.sample_stb = 1'b1;
            d.sample     = i_meas_value;
            d.tick       = '0;
            d.units      = '0;
          end
        end
      end
      ST_EVAL: begin
        // Channels evaluate now, so the report cycle reads this scan's flags, not the last.
        d.st       = ST_REPORT;
      end
      ST_REPORT: begin
        for (int i = 0; i < NUM_CH; i++) begin
          d.status[i]  = det[i] & en_eff[i];
          d.ind_pin[i] = (det[i] & en_eff[i]) ~^ i_indicator_active_high[i];
        end
        // The alert level is the polarity bit when active, its inverse otherwise.
        d.alert_n   = ((|(det & en_eff)) | q.err_seen) ~^ i_alert_active_high;
        d.scan_done = 1'b1;
        d.st        = ST_SLEEP;
        d.tick      = '0;
        d.units     = '0;
      end
      default: begin
        d.st = ST_SLEEP;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register. Indicators reset to inactive for the default low-true pins.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q         <= '0;
      q.st      <= ST_MEAS;
      q.ind_pin <= '1;
      q.alert_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Channel processors, one per channel, each on its own carrier.
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    rctc_chan_if cif ();
    assign cif.enable     = en_eff[g];
    assign cif.sign_sel   = i_data_sign_select[g];
    assign cif.gain       = i_sensitivity_step[g];
    assign cif.lp_mode    = i_low_power_mode;
    assign cif.np_exp     = i_normal_drift_exponent;
    assign cif.lp_exp     = i_lowpower_drift_exponent;
    assign cif.sample_stb = q.sample_stb && (q.ch == 2'(g));
    assign cif.sample     = q.sample;
    assign cif.eval_stb   = q.eval_stb;
    assign det[g]         = cif.detect;
    assign res[g]         = cif.result;

    rctc_chan u_chan (
      .i_clock  (i_clock),
      .i_arst_n (i_arst_n),
      .ch       (cif.chan)
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all from registers except o_low_power_state, which decodes the state.
  assign o_meas_req             = q.meas_req;
  assign o_meas_chan            = q.ch;
  assign o_low_power_state      = (q.st == ST_SLEEP);
  assign o_scan_done            = q.scan_done;
  assign o_detect_indicator_pin = q.ind_pin;
  assign o_alert_pin_n          = q.alert_n;
  assign o_detect_status        = q.status;
  assign o_channel_result       = res;

endmodule // rctc_top

// File: rctc_pkg.sv
// Shared constants, types and the notes for the resonant touch channel block.
package rctc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Channel geometry and widths.
  localparam int unsigned NUM_CH      = 4;
  localparam int unsigned MEAS_W      = 16;
  localparam int unsigned RES_W       = 16;
  localparam int unsigned GAIN_W      = 6;
  localparam int unsigned EXP_W       = 4;
  localparam int unsigned MTIME_W     = 4;
  localparam int unsigned WAIT_W      = 8;
  localparam int unsigned BASE_W      = MEAS_W + 7;
  localparam int unsigned TICK_W      = 24;
  localparam int unsigned UNIT_W      = WAIT_W + 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing: one time unit is 100 cycles, half a microsecond of the 200 MHz clock.
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned TIME_UNIT_US   = 500;
  localparam int unsigned UNIT_CYCLES    = (TIME_UNIT_US * 1000) / CLK_PERIOD_PS;
  localparam int unsigned LP_WAIT_SHIFT  = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Baseline arithmetic works in 1/72 steps; the low power divisor 9 is 72/8.
  localparam int unsigned BASE_DIV       = 72;
  localparam int unsigned LP_STEP_SHIFT  = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // Gain: 2^(g/8) in Q7, eight mantissas, whole octaves by shifting.
  localparam int unsigned GAIN_FRAC      = 7;
  localparam logic [7:0]  GAIN_MANT [8]  = '{8'h80, 8'h8b, 8'h98, 8'ha6, 8'hb5, 8'hc5, 8'hd7, 8'hea};
  localparam logic signed [RES_W-1:0] DETECT_THRESHOLD = 16'sh0400;
  localparam logic signed [RES_W-1:0] RES_MAX = 16'sh7fff;
  localparam logic signed [RES_W-1:0] RES_MIN = -16'sh7fff - 16'sh0001;

  ////////////////////////////////////////////////////////////////////////////////
  // State of the scan sequencer.
  typedef enum logic [2:0] {
    ST_SLEEP,
    ST_MEAS,
    ST_EVAL,
    ST_REPORT
  } rctc_state_e;

  typedef struct packed {
    rctc_state_e              st;
    logic [1:0]               ch;
    logic [TICK_W-1:0]        tick;
    logic [UNIT_W-1:0]        units;
    logic                     meas_req;
    logic                     sample_stb;
    logic                     eval_stb;
    logic                     err_seen;
    logic                     scan_done;
    logic [NUM_CH-1:0]        ind_pin;
    logic                     alert_n;
    logic [NUM_CH-1:0]        status;
    logic [MEAS_W-1:0]        sample;
  } rctc_top_s;

  typedef struct packed {
    logic                     primed;
    logic [MEAS_W-1:0]        meas;
    logic [BASE_W-1:0]        base72;
    logic signed [RES_W-1:0]  result;
    logic                     detect;
  } rctc_chan_s;

endpackage

// File: rctc_chan_if.sv
// Carrier between the scan sequencer and one channel processor.
`timescale 1ns/1ps
interface rctc_chan_if;
  import rctc_pkg::*;
  logic                     enable;       // Channel active.
  logic                     sign_sel;     // Data sign select.
  logic [GAIN_W-1:0]        gain;         // Sensitivity step.
  logic                     lp_mode;      // Low power mode.
  logic [EXP_W-1:0]         np_exp;       // Normal drift exponent.
  logic [EXP_W-1:0]         lp_exp;       // Low-power drift exponent.
  logic                     sample_stb;   // New measurement pulse.
  logic [MEAS_W-1:0]        sample;       // Measured value.
  logic                     eval_stb;     // Evaluate pulse.
  logic signed [RES_W-1:0]  result;       // Channel result.
  logic                     detect;       // Detection flag.

  modport seq  (output enable, sign_sel, gain, lp_mode, np_exp, lp_exp, sample_stb, sample, eval_stb,
                input result, detect);
  modport chan (input enable, sign_sel, gain, lp_mode, np_exp, lp_exp, sample_stb, sample, eval_stb,
                output result, detect);
endinterface // rctc_chan_if

// File: rctc_chan.sv
// One channel: baseline tracking, gain scaling and threshold detection.
`timescale 1ns/1ps
module rctc_chan
  import rctc_pkg::*;
(
  input  wire logic i_clock,   // 200 MHz clock.
  input  wire logic i_arst_n,  // Asynchronous reset, active low.
  rctc_chan_if.chan ch         // Link to the sequencer.
);

  rctc_chan_s q, d;

  logic [BASE_W-1:0]        meas72;
  logic [BASE_W-1:0]        step72;
  logic signed [BASE_W:0]   diff72;
  logic signed [BASE_W:0]   shift;
  logic [8+15:0]            mult;
  logic signed [BASE_W+25:0] prod;

  ////////////////////////////////////////////////////////////////////////////////
  // Arithmetic shared by result and baseline paths.
  always_comb begin
    meas72 = BASE_W'(q.meas * BASE_DIV);
    // Low power steps are 8/72 = 1/9 of the exponent power.
    step72 = ch.lp_mode ? BASE_W'(({{(BASE_W-1){1'b0}}, 1'b1} << ch.lp_exp) << LP_STEP_SHIFT)
                        : BASE_W'({{(BASE_W-1){1'b0}}, 1'b1} << ch.np_exp);
    diff72 = $signed({1'b0, meas72}) - $signed({1'b0, q.base72});
    // A touch lowers frequency, so the default sign reports base minus measurement.
    shift  = (BASE_W+1)'(ch.sign_sel ? (diff72 / $signed(BASE_DIV)) : (-diff72 / $signed(BASE_DIV)));
    mult   = 24'({16'h0000, GAIN_MANT[ch.gain[2:0]]} << ch.gain[5:3]);
    prod   = (shift * $signed({1'b0, mult})) >>> GAIN_FRAC;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state: capture samples, then on evaluate update result and baseline.
  always_comb begin
    d = q;
    if (ch.sample_stb) begin
      d.meas = ch.sample;
    end
    if (ch.eval_stb) begin
      if (!ch.enable) begin
        d.detect = 1'b0;
      end else if (!q.primed) begin
        // First sample seeds the baseline so the result starts at zero.
        d.primed = 1'b1;
        d.base72 = meas72;
        d.result = '0;
        d.detect = 1'b0;
      end else begin
        if (prod > $signed(RES_MAX)) begin
          d.result = RES_MAX;
        end else if (prod < $signed(RES_MIN)) begin
          d.result = RES_MIN;
        end else begin
          d.result = RES_W'(prod);
        end
        d.detect = (d.result > DETECT_THRESHOLD);
        // Move toward the measurement by at most one step, so a steady level is absorbed.
        if (meas72 > q.base72) begin
          d.base72 = ((meas72 - q.base72) > step72) ? q.base72 + step72 : meas72;
        end else begin
          d.base72 = ((q.base72 - meas72) > step72) ? q.base72 - step72 : meas72;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ch.result = q.result;
  assign ch.detect = q.detect;

endmodule // rctc_chan

// File: rctc_top_assertions.sv
// Port-level checker for the resonant touch channel block.
`timescale 1ns/1ps
module rctc_top_assertions
  import rctc_pkg::*;
#(
  parameter int unsigned P_NUM_CH      = NUM_CH,     // Channel count of the build.
  parameter int unsigned P_UNIT_CYCLES = UNIT_CYCLES // Cycles in one time unit.
) (
  input wire logic                          i_clock,                 // Clock.
  input wire logic                          i_arst_n,                // Reset, active low.
  input wire logic [NUM_CH-1:0]             i_chan_enable,           // Enables.
  input wire logic [MTIME_W-1:0]            i_meas_time_sel,         // Measure time.
  input wire logic [WAIT_W-1:0]             i_scan_wait,             // Sleep units.
  input wire logic                          i_low_power_mode,        // Low power.
  input wire logic [NUM_CH-1:0]             i_indicator_active_high, // Pin levels.
  input wire logic                          i_alert_active_high,     // Alert level.
  input wire logic                          o_meas_req,              // Measuring.
  input wire logic [1:0]                    o_meas_chan,             // Channel.
  input wire logic                          o_low_power_state,       // Sleeping.
  input wire logic                          o_scan_done,             // End of scan.
  input wire logic [NUM_CH-1:0]             o_detect_indicator_pin,  // Indicators.
  input wire logic                          o_alert_pin_n,           // Alert pin.
  input wire logic [NUM_CH-1:0]             o_detect_status,         // Flags.
  input wire logic [NUM_CH-1:0][RES_W-1:0]  o_channel_result         // Results.
);
  logic [NUM_CH-1:0] en_eff;
  logic [NUM_CH-1:0] over_thr;
  logic [15:0]       mcnt_q;
  logic [15:0]       slp_q;
  int unsigned       meas_len;
  int unsigned       slp_len;

  // Expected window lengths; the two-channel build ignores the enable pins.
  always_comb begin
    en_eff = (P_NUM_CH == 2) ? 4'h3 : i_chan_enable;
    for (int c = 0; c < NUM_CH; c++) over_thr[c] = $signed(o_channel_result[c]) > DETECT_THRESHOLD;
    meas_len = (i_meas_time_sel + 1) * P_UNIT_CYCLES;
    slp_len = ((i_scan_wait == 8'h00) ? 1 : i_scan_wait * (i_low_power_mode ? 4 : 1)) * P_UNIT_CYCLES;
  end

  // Run-length counters; too long for a repetition operator.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mcnt_q <= 16'h0000;
      slp_q  <= 16'h0000;
    end else begin
      mcnt_q <= o_meas_req ? mcnt_q + 16'h0001 : 16'h0000;
      slp_q  <= o_low_power_state ? slp_q + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  property p_meas_en; o_meas_req |-> en_eff[o_meas_chan]; endproperty
  a_meas_en: assert property (p_meas_en) else $error("disabled channel measured");
  property p_no_meas_sleep; o_low_power_state |-> !o_meas_req; endproperty
  a_no_meas_sleep: assert property (p_no_meas_sleep) else $error("measure while asleep");
  property p_done_sleep; o_scan_done |-> o_low_power_state ##1 !o_scan_done; endproperty
  a_done_sleep: assert property (p_done_sleep) else $error("scan end order wrong");
  property p_status; o_scan_done |-> o_detect_status == (en_eff & over_thr); endproperty
  a_status: assert property (p_status) else $error("status not matching results");
  property p_ind; o_scan_done |-> o_detect_indicator_pin == ~(o_detect_status ^ i_indicator_active_high); endproperty
  a_ind: assert property (p_ind) else $error("indicator level wrong");
  property p_alert; o_scan_done && (|o_detect_status) |-> o_alert_pin_n == i_alert_active_high; endproperty
  a_alert: assert property (p_alert) else $error("alert not raised on detect");
  property p_meas_len; $fell(o_meas_req) |-> mcnt_q + 1 >= meas_len && mcnt_q <= meas_len + 1; endproperty
  a_meas_len: assert property (p_meas_len) else $error("measure window length wrong");
  property p_sleep_len; $fell(o_low_power_state) |-> slp_q + 2 >= slp_len && slp_q <= slp_len + 2; endproperty
  a_sleep_len: assert property (p_sleep_len) else $error("sleep length wrong");
endmodule // rctc_top_assertions

bind rctc_top rctc_top_assertions #(.P_NUM_CH(P_NUM_CH), .P_UNIT_CYCLES(P_UNIT_CYCLES)) u_chk (
  .i_clock(i_clock), .i_arst_n(i_arst_n), .i_chan_enable(i_chan_enable), .i_meas_time_sel(i_meas_time_sel),
  .i_scan_wait(i_scan_wait), .i_low_power_mode(i_low_power_mode), .i_alert_active_high(i_alert_active_high),
  .i_indicator_active_high(i_indicator_active_high), .o_meas_req(o_meas_req), .o_meas_chan(o_meas_chan),
  .o_low_power_state(o_low_power_state), .o_scan_done(o_scan_done), .o_alert_pin_n(o_alert_pin_n),
  .o_detect_indicator_pin(o_detect_indicator_pin), .o_detect_status(o_detect_status),
  .o_channel_result(o_channel_result));

// File: rctc_front_model.sv
// Behavioural measurement front end that answers the scan sequencer.
`timescale 1ns/1ps
module rctc_front_model
  import rctc_pkg::*;
(
  input  wire logic                          i_clock,      // Clock.
  input  wire logic                          i_meas_req,   // Window open.
  input  wire logic [1:0]                    i_meas_chan,  // Channel measured.
  input  wire logic [NUM_CH-1:0][MEAS_W-1:0] i_level,      // Count per channel.
  input  wire logic                          i_err_cmd,    // Raise an error.
  output logic      [MEAS_W-1:0]             o_meas_value, // Count out.
  output logic                               o_meas_error  // Error level.
);
  logic [MEAS_W-1:0] junk_q = 16'h0000;

  // Outside a window the count flips each cycle, so a late sample never looks valid.
  always_ff @(posedge i_clock) junk_q <= ~o_meas_value;
  assign o_meas_value = i_meas_req ? i_level[i_meas_chan] : junk_q;
  assign o_meas_error = i_err_cmd & i_meas_req;
endmodule // rctc_front_model

// File: tb.sv
// Self-checking bench for the resonant touch channel block.
`timescale 1ns/1ps
module tb;
  import rctc_pkg::*;
  localparam int unsigned U = 8;
  logic clk = 1'b0, arst_n = 1'b0, lpm = 1'b0, aah = 1'b0, err_cmd = 1'b0;
  logic req, req2, done, lps, alert, merr;
  logic [NUM_CH-1:0] en = 4'hf, sgn = 4'h0, iah = 4'h0, ind, stat, seen2 = 4'h0;
  logic [NUM_CH-1:0][GAIN_W-1:0] gain = '0;
  logic [NUM_CH-1:0][MEAS_W-1:0] lvl = '0;
  logic [NUM_CH-1:0][RES_W-1:0] res;
  logic [EXP_W-1:0] nexp = 4'h0, lexp = 4'h0;
  logic [MTIME_W-1:0] sel = 4'h0;
  logic [WAIT_W-1:0] wt = 8'h01;
  logic [MEAS_W-1:0] mval;
  logic [1:0] mch, mch2;
  logic [15:0] rnd = 16'heeea;
  int num_errors = 0, checks = 0, cyc = 0;

  rctc_top #(.P_NUM_CH(4), .P_UNIT_CYCLES(U)) uut (.i_clock(clk), .i_arst_n(arst_n), .i_chan_enable(en),
    .i_data_sign_select(sgn), .i_sensitivity_step(gain), .i_normal_drift_exponent(nexp),
    .i_lowpower_drift_exponent(lexp), .i_low_power_mode(lpm), .i_meas_time_sel(sel), .i_scan_wait(wt),
    .i_indicator_active_high(iah), .i_alert_active_high(aah), .i_meas_value(mval), .i_meas_error(merr),
    .o_meas_req(req), .o_meas_chan(mch), .o_low_power_state(lps), .o_scan_done(done),
    .o_detect_indicator_pin(ind), .o_alert_pin_n(alert), .o_detect_status(stat), .o_channel_result(res));
  // Two-channel build: its enables are tied off and must be ignored.
  rctc_top #(.P_NUM_CH(2), .P_UNIT_CYCLES(U)) uut2 (.i_clock(clk), .i_arst_n(arst_n), .i_chan_enable(4'h0),
    .i_data_sign_select(sgn), .i_sensitivity_step(gain), .i_normal_drift_exponent(nexp),
    .i_lowpower_drift_exponent(lexp), .i_low_power_mode(lpm), .i_meas_time_sel(sel), .i_scan_wait(wt),
    .i_indicator_active_high(iah), .i_alert_active_high(aah), .i_meas_value(mval), .i_meas_error(merr),
    .o_meas_req(req2), .o_meas_chan(mch2), .o_low_power_state(), .o_scan_done(),
    .o_detect_indicator_pin(), .o_alert_pin_n(), .o_detect_status(), .o_channel_result());
  rctc_front_model u_front (.i_clock(clk), .i_meas_req(req), .i_meas_chan(mch), .i_level(lvl),
    .i_err_cmd(err_cmd), .o_meas_value(mval), .o_meas_error(merr));

  // Clock at 200 MHz.
  initial forever #2.5 clk = ~clk;

  // Cycle count and the channels the two-channel build visits.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (req2 === 1'b1) seen2[mch2] <= 1'b1;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Shift times gain, exact for shifts that are multiples of 128, then polarity and saturation.
  function automatic logic [RES_W-1:0] exp_res(input int d, input logic [GAIN_W-1:0] g, input logic s);
    int r;
    r = d * int'(GAIN_MANT[g[2:0]]) * (1 << g[5:3]) / 128;
    if (s) r = -r;
    if (r > 32767) r = 32767;
    if (r < -32768) r = -32768;
    return r[RES_W-1:0];
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic chk_near(input string what, input int exp, input logic signed [RES_W-1:0] got, input int tol);
    checks++;
    if ($isunknown(got) || got > exp + tol || got < exp - tol) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Reset for 8 cycles; the caller sets the configuration and releases it.
  task automatic do_reset();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (7) @(posedge clk);
    #1;
    chk("reset_pins", {4'hf, 1'b1, 4'h0, 1'b0}, {ind, alert, stat, req});
  endtask

  // Wait, bounded, for the end-of-scan pulse.
  task automatic scan();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 3000);
    chk("scan_done", 1, done);
  endtask

  initial begin : main
    int d[NUM_CH];
    logic [NUM_CH-1:0] ed;
    logic [NUM_CH-1:0][RES_W-1:0] held;
    int per[2];
    int t0;
    // Random shifts, gains and polarities; the second scan shows the scaled change.
    for (int it = 0; it < 6; it++) begin
      do_reset();
      @(posedge clk);
      rnd = lfsr(rnd);
      {aah, iah, wt, sel} <= {rnd[8:4], 6'h00, rnd[3:2], 2'b00, rnd[1:0]};
      {en, nexp, lexp, lpm} <= {4'hf, 9'h000};
      for (int c = 0; c < NUM_CH; c++) begin
        rnd = lfsr(rnd);
        gain[c] <= (it == 0 && c == 0) ? 6'h3f : rnd[5:0];
        sgn[c] <= (it == 0) ? 1'b0 : rnd[6];
        d[c] = (it == 0 && c == 0) ? 1024 : (rnd[7] ? 128 : -128);
        lvl[c] <= {2'b01, rnd[13:0]};
      end
      arst_n <= 1'b1;
      scan();
      for (int c = 0; c < NUM_CH; c++) chk("seed_result", 0, res[c]);
      @(posedge clk);
      for (int c = 0; c < NUM_CH; c++) lvl[c] <= MEAS_W'(int'(lvl[c]) - d[c]);
      scan();
      for (int c = 0; c < NUM_CH; c++) begin
        ed[c] = $signed(exp_res(d[c], gain[c], sgn[c])) > DETECT_THRESHOLD;
        chk("result", exp_res(d[c], gain[c], sgn[c]), res[c]);
        chk("status", ed[c], stat[c]);
      end
      chk("indicator", NUM_CH'(~(ed ^ iah)), ind);
      chk("alert", 1'(~((|ed) ^ aah)), alert);
      held = res;
      @(posedge clk);
      rnd = lfsr(rnd);
      en <= rnd[3:0];
      scan();
      for (int c = 0; c < NUM_CH; c++) if (!en[c]) chk("held", {held[c], 1'b0}, {res[c], stat[c]});
    end
    $display("Test of results, flags and pins finished");
    // Same baseline step in both modes; low power sleeps four times as long.
    for (int m = 0; m < 2; m++) begin
      do_reset();
      @(posedge clk);
      {lpm, nexp, lexp} <= m ? {1'b1, 4'h0, 4'h6} : {1'b0, 4'h9, 4'h0};
      {en, gain, sgn, sel, wt} <= {4'hf, 24'h000000, 4'h0, 4'h1, 8'h02};
      arst_n <= 1'b1;
      scan();
      @(posedge clk);
      lvl[0] <= lvl[0] - 16'h0080;
      scan();
      chk("drift_first", 16'h0080, res[0]);
      t0 = cyc;
      repeat (3) scan();
      per[m] = (cyc - t0) / 3;
      chk_near("drift_step", 107, res[0], 1);
    end
    chk("lp_rate", 3 * 2 * U, per[1] - per[0]);
    $display("Test of drift rates finished");
    // A steady step is absorbed by fast tracking.
    do_reset();
    @(posedge clk);
    {lpm, nexp} <= {1'b0, 4'hf};
    arst_n <= 1'b1;
    scan();
    @(posedge clk);
    lvl[1] <= lvl[1] + 16'h0300;
    repeat (6) scan();
    chk_near("absorbed", 0, res[1], 1);
    chk("absorbed_flag", 0, stat[1]);
    $display("Test of absorption finished");
    // Front-end error raises the alert for one scan in both polarities.
    for (int a = 0; a < 2; a++) begin
      @(posedge clk);
      {aah, err_cmd} <= {a[0], 1'b1};
      scan();
      chk("alert_err", a, alert);
      @(posedge clk);
      err_cmd <= 1'b0;
      scan();
      chk("alert_idle", !a, alert);
    end
    chk("two_ch_scan", 4'h3, seen2);
    $display("Test of error alert and two-channel build finished");
    give_verdict();
  end

  // Hang guard, well above the expected run length.
  initial begin : watchdog
    repeat (60000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule // tb
